// >>> hdl/ddr_ctl_consts.vh
// constants for the ddr command and init controller
`ifndef DDR_CTL_CONSTS_VH
`define DDR_CTL_CONSTS_VH
// register offsets on the software port
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_CMD         4'h2
`define REG_ADDR        4'h3
`define REG_MODE        4'h4
`define REG_EMODE       4'h5
`define REG_WDATA       4'h6
`define REG_RDATA       4'h7
// ctrl bits
`define CTRL_START      0
`define CTRL_SR_ENTER   1
`define CTRL_SR_EXIT    2
`define CTRL_PD_ENTER   3
`define CTRL_PD_EXIT    4
// status bits
`define ST_INIT_DONE    0
`define ST_BUSY         1
`define ST_SELF_REF     2
`define ST_POWER_DOWN   3
`define ST_ROW_OPEN     4
`define ST_REFUSED      5
// command codes in REG_CMD[2:0]
`define OP_ACT          3'h1
`define OP_RD           3'h2
`define OP_WR           3'h3
`define OP_PRE          3'h4
`define OP_REF          3'h5
`define OP_BST          3'h6
// {ras_n,cas_n,we_n} encodings
`define ENC_NOP         3'h7
`define ENC_ACT         3'h3
`define ENC_RD          3'h5
`define ENC_WR          3'h4
`define ENC_PRE         3'h2
`define ENC_BST         3'h6
`define ENC_REF         3'h1
`define ENC_MRS         3'h0
// address bit positions
`define AP_BIT          10
`define DLL_RESET_BIT   8
// timing: 200 us wait at 100 MHz, 10 ns period
`define CLK_NS          10
`define INIT_WAIT_US    200
`define INIT_WAIT_CYC   ((`INIT_WAIT_US * 1000) / `CLK_NS)
`define LOCK_WAIT_CYC   8'hC8
`define MRS_CYC         16'h0002
`define TRP_CYC         16'h0003
`define TWR_CYC         2
`define TRFC_CYC        16'h0008
`define BURST_LEN       4
`define RD_AP_HOLD      16'h0005
`define WR_AP_HOLD      16'h0008
`define REF_COUNT       2
// reset values
`define MODE_RST        15'h0032
`define EMODE_RST       15'h4000
`endif

// >>> hdl/ddr_wait_timer.v
// down-counting wait timer used for command spacing
module ddr_wait_timer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        load,
  input  wire [15:0] count,
  output wire        done
);
  reg [15:0] left_r;

  // reload wins over counting down
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_r <= 16'h0000;
    end else if (load) begin
      left_r <= count;
    end else if (left_r != 16'h0000) begin
      left_r <= left_r - 16'h0001;
    end
  end

  assign done = (left_r == 16'h0000) && !load;
endmodule // ddr_wait_timer

// >>> hdl/ddr_ctl.v
// controller that initialises and drives a four-bank ddr sdram
// Contract
// RULE1: command pins encode cs ras cas we
// RULE2: precharge with ap bit hits all banks
// RULE3: mode operand on a0-a12 plus bank
// RULE4: mode write only after precharge plus trp
// RULE5: read autoprecharge holds bank bl/2+trp
// RULE6: write autoprecharge holds bank bl/2+1+twr+trp
// RULE7: byte mask high discards that beat
// RULE8: masks matter only during write bursts
// RULE9: refresh with cke falling enters self refresh
// RULE10: self refresh exit with cke high, nop
// RULE11: cke low with nop enters power-down
// RULE12: cke held low during power-up
// RULE13: wait 200 us before any command
// RULE14: then nop and raise cke
// RULE15: precharge all before mode programming
// RULE16: extended mode write enables loop
// RULE17: mode write a8 high, 200 cycles
// RULE18: precharge all again afterwards
// RULE19: at least two auto refreshes
// RULE20: final mode write with a8 low
// RULE21: extended mode uses ba0=1 ba1=0
// RULE22: two cycles after a mode write
// RULE23: activate before access, precharge before reopen
//
// Implementation choices: the address map and strobed register access.
`include "ddr_ctl_consts.vh"
module ddr_ctl #(
  parameter INIT_WAIT = `INIT_WAIT_CYC
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         cke,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [12:0] addr,
  output reg  [1:0]  bank,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  input  wire [15:0] dq_in,
  output reg         lower_byte_strobe_out,
  output reg         upper_byte_strobe_out,
  output reg         strobe_oe,
  input  wire        lower_byte_strobe_in,
  input  wire        upper_byte_strobe_in,
  output reg         lower_byte_mask,
  output reg         upper_byte_mask
);
  // one-hot states
  localparam S_WAIT  = 12'h001;
  localparam S_CKE   = 12'h002;
  localparam S_PRE1  = 12'h004;
  localparam S_EXTENDED_MODE_REGISTER_WRITE  = 12'h008;
  localparam S_MRS1  = 12'h010;
  localparam S_PRE2  = 12'h020;
  localparam S_REF   = 12'h040;
  localparam S_MRS2  = 12'h080;
  localparam S_IDLE  = 12'h100;
  localparam S_SREF  = 12'h200;
  localparam S_PDN   = 12'h400;
  localparam S_GAP   = 12'h800;

  reg [11:0] state_r;
  reg [14:0] mode_r;
  reg [14:0] emode_r;
  reg [2:0]  cmd_op_r;
  reg [14:0] cmd_addr_r;
  reg        cmd_pend_r;
  reg [15:0] wdata_r;
  reg [1:0]  wmask_r;
  reg [15:0] rdata_r;
  reg [3:0]  open_r;
  reg [1:0]  ref_cnt_r;
  reg [7:0]  lock_cnt_r;
  reg        refused_r;
  reg        sr_req_r;
  reg        sr_exit_r;
  reg        pd_req_r;
  reg        pd_exit_r;
  reg [3:0]  wr_ph_r;
  reg [15:0] bank_hold_r [0:3];
  reg        tload;
  reg [15:0] tcount;
  wire       tdone;
  // pin input synchroniser for read data
  reg [15:0] dq_s1_r;
  reg [15:0] dq_s2_r;
  reg [15:0] dq_s3_r;
  integer    i;

  // hold time after an autoprecharge access
  function [15:0] ap_hold;
    input is_wr;
    begin
      if (is_wr) begin
        ap_hold = `WR_AP_HOLD;
      end else begin
        ap_hold = `RD_AP_HOLD;
      end
    end
  endfunction

  ddr_wait_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (tload),
    .count   (tcount),
    .done    (tdone)
  );

  // read data register, a change counts once stages two and three agree
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      dq_s3_r <= 16'h0000;
      rdata_r <= 16'h0000;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      if (dq_s2_r == dq_s3_r) begin
        rdata_r <= dq_s3_r;
      end
    end
  end

  // software register read, data one cycle later
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_STATUS: reg_rdata <= {26'h0, refused_r, (open_r != 4'h0), state_r == S_PDN,
                                   state_r == S_SREF, state_r != S_IDLE, state_r == S_IDLE};
        `REG_CMD:    reg_rdata <= {28'h0, cmd_pend_r, cmd_op_r};
        `REG_ADDR:   reg_rdata <= {17'h0, cmd_addr_r};
        `REG_MODE:   reg_rdata <= {17'h0, mode_r};
        `REG_EMODE:  reg_rdata <= {17'h0, emode_r};
        `REG_WDATA:  reg_rdata <= {14'h0, wmask_r, wdata_r};
        `REG_RDATA:  reg_rdata <= {16'h0, rdata_r};
        default:     reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // main sequencer and pin drive
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= S_WAIT;
      // RULE12: cke low held through power-up
      cke        <= 1'b0;
      cs_n       <= 1'b1;
      ras_n      <= 1'b1;
      cas_n      <= 1'b1;
      we_n       <= 1'b1;
      addr       <= 13'h0000;
      bank       <= 2'h0;
      dq_out     <= 16'h0000;
      dq_oe      <= 1'b0;
      lower_byte_strobe_out <= 1'b0;
      upper_byte_strobe_out <= 1'b0;
      strobe_oe  <= 1'b0;
      lower_byte_mask <= 1'b0;
      upper_byte_mask <= 1'b0;
      mode_r     <= `MODE_RST;
      emode_r    <= `EMODE_RST;
      cmd_op_r   <= 3'h0;
      cmd_addr_r <= 15'h0000;
      cmd_pend_r <= 1'b0;
      wdata_r    <= 16'h0000;
      wmask_r    <= 2'h0;
      open_r     <= 4'h0;
      ref_cnt_r  <= 2'h0;
      lock_cnt_r <= 8'h00;
      refused_r  <= 1'b0;
      sr_req_r   <= 1'b0;
      sr_exit_r  <= 1'b0;
      pd_req_r   <= 1'b0;
      pd_exit_r  <= 1'b0;
      wr_ph_r    <= 4'h0;
      tload      <= 1'b1;
      tcount     <= INIT_WAIT[15:0];
      for (i = 0; i < 4; i = i + 1) begin
        bank_hold_r[i] <= 16'h0000;
      end
    end else begin
      // defaults: nop, timer idle
      tload <= 1'b0;
      cs_n  <= 1'b0;
      {ras_n, cas_n, we_n} <= `ENC_NOP;
      for (i = 0; i < 4; i = i + 1) begin
        if (bank_hold_r[i] != 16'h0000) begin
          bank_hold_r[i] <= bank_hold_r[i] - 16'h0001;
        end
      end
      if (lock_cnt_r != 8'h00) begin
        lock_cnt_r <= lock_cnt_r - 8'h01;
      end
      // software writes; ctrl requests stick until served
      if (reg_wr) begin
        case (reg_addr)
          `REG_CTRL: begin
            if (reg_wdata[`CTRL_SR_ENTER]) sr_req_r <= 1'b1;
            if (reg_wdata[`CTRL_SR_EXIT]) sr_exit_r <= 1'b1;
            if (reg_wdata[`CTRL_PD_ENTER]) pd_req_r <= 1'b1;
            if (reg_wdata[`CTRL_PD_EXIT]) pd_exit_r <= 1'b1;
            if (reg_wdata[`CTRL_START]) refused_r <= 1'b0;
          end
          `REG_CMD: begin
            cmd_op_r   <= reg_wdata[2:0];
            cmd_pend_r <= 1'b1;
          end
          `REG_ADDR:  cmd_addr_r <= reg_wdata[14:0];
          `REG_MODE:  mode_r <= reg_wdata[14:0];
          `REG_EMODE: emode_r <= reg_wdata[14:0];
          `REG_WDATA: begin
            wdata_r <= reg_wdata[15:0];
            wmask_r <= reg_wdata[17:16];
          end
          default: ;
        endcase
      end
      // write burst drive: four beats, masks only here
      dq_oe     <= (wr_ph_r != 4'h0);
      strobe_oe <= (wr_ph_r != 4'h0);
      if (wr_ph_r != 4'h0) begin
        wr_ph_r <= wr_ph_r - 4'h1;
        dq_out  <= wdata_r;
        lower_byte_strobe_out <= wr_ph_r[0];
        upper_byte_strobe_out <= wr_ph_r[0];
        // RULE7: mask set discards byte
        lower_byte_mask <= wmask_r[0];
        upper_byte_mask <= wmask_r[1];
      end else begin
        // RULE8: masks inert outside write
        lower_byte_mask <= 1'b0;
        upper_byte_mask <= 1'b0;
        lower_byte_strobe_out <= 1'b0;
        upper_byte_strobe_out <= 1'b0;
      end
      case (state_r)
        S_WAIT: begin
          cs_n <= 1'b1;
          // RULE13: 200 us wait first
          if (tdone) begin
            state_r <= S_CKE;
          end
        end
        S_CKE: begin
          // RULE14: nop and cke high in the same cycle
          cke     <= 1'b1;
          state_r <= S_PRE1;
        end
        S_PRE1: begin
          // RULE15: precharge all first
          {ras_n, cas_n, we_n} <= `ENC_PRE;
          addr[`AP_BIT] <= 1'b1;
          tload   <= 1'b1;
          tcount  <= `TRP_CYC;
          state_r <= S_GAP;
          ref_cnt_r <= 2'h0;
        end
        S_GAP: begin
          // RULE4: trp before mode write
          // RULE22: mode write gap
          if (tdone) begin
            if (lock_cnt_r == 8'h00 && ref_cnt_r == 2'h3) begin
              state_r <= S_IDLE;
            end else if (ref_cnt_r == 2'h3) begin
              state_r <= S_GAP;
            end else if (ref_cnt_r == 2'h0) begin
              state_r <= S_EXTENDED_MODE_REGISTER_WRITE;
              ref_cnt_r <= 2'h1;
            end else if (ref_cnt_r == 2'h1) begin
              state_r <= S_MRS1;
            end else begin
              state_r <= S_REF;
            end
          end
        end
        S_EXTENDED_MODE_REGISTER_WRITE: begin
          // RULE16: loop enable bit 0 low
          // RULE21: ba0=1 ba1=0 selects extended
          {ras_n, cas_n, we_n} <= `ENC_MRS;
          addr    <= emode_r[12:0] & 13'h1FFE;
          bank    <= 2'h1;
          tload   <= 1'b1;
          tcount  <= `MRS_CYC;
          state_r <= S_GAP;
          if (ref_cnt_r == 2'h0) ref_cnt_r <= 2'h1;
        end
        S_MRS1: begin
          // RULE17: loop reset, lock wait
          // RULE3: operand on a0-a12 and bank
          {ras_n, cas_n, we_n} <= `ENC_MRS;
          addr    <= mode_r[12:0] | 13'h0100;
          bank    <= 2'h0;
          lock_cnt_r <= `LOCK_WAIT_CYC;
          tload   <= 1'b1;
          tcount  <= `MRS_CYC;
          state_r <= S_PRE2;
        end
        S_PRE2: begin
          if (tdone) begin
            // RULE18: precharge all again
            {ras_n, cas_n, we_n} <= `ENC_PRE;
            addr[`AP_BIT] <= 1'b1;
            tload   <= 1'b1;
            tcount  <= `TRP_CYC;
            ref_cnt_r <= 2'h0;
            state_r <= S_REF;
          end
        end
        S_REF: begin
          // RULE19: two auto refreshes
          if (tdone) begin
            if (ref_cnt_r == `REF_COUNT) begin
              state_r <= S_MRS2;
            end else begin
              {ras_n, cas_n, we_n} <= `ENC_REF;
              ref_cnt_r <= ref_cnt_r + 2'h1;
              tload   <= 1'b1;
              tcount  <= `TRFC_CYC;
            end
          end
        end
        S_MRS2: begin
          // RULE20: a8 low final write
          {ras_n, cas_n, we_n} <= `ENC_MRS;
          addr    <= mode_r[12:0] & 13'h1EFF;
          bank    <= 2'h0;
          tload   <= 1'b1;
          tcount  <= `MRS_CYC;
          ref_cnt_r <= 2'h3;
          state_r <= S_GAP;
        end
        S_IDLE: begin
          if (!tdone) begin
            state_r <= S_IDLE;
          end else if (sr_req_r && open_r == 4'h0) begin
            // RULE9: refresh while cke falls
            sr_req_r <= 1'b0;
            {ras_n, cas_n, we_n} <= `ENC_REF;
            cke     <= 1'b0;
            state_r <= S_SREF;
          end else if (pd_req_r) begin
            // RULE11: nop while cke falls
            pd_req_r <= 1'b0;
            cke     <= 1'b0;
            state_r <= S_PDN;
          end else if (cmd_pend_r) begin
            cmd_pend_r <= reg_wr && reg_addr == `REG_CMD;
            bank    <= cmd_addr_r[14:13];
            addr    <= cmd_addr_r[12:0];
            // RULE5: read autoprecharge hold
            // RULE6: write autoprecharge hold
            // RULE23: row state tracking
            if (bank_hold_r[cmd_addr_r[14:13]] != 16'h0000 ||
                ((cmd_op_r == `OP_RD || cmd_op_r == `OP_WR) && !open_r[cmd_addr_r[14:13]]) ||
                (cmd_op_r == `OP_ACT && open_r[cmd_addr_r[14:13]]) ||
                (cmd_op_r == `OP_REF && open_r != 4'h0) ||
                (cmd_op_r == `OP_RD && lock_cnt_r != 8'h00)) begin
              refused_r <= 1'b1;
            end else begin
              case (cmd_op_r)
                `OP_ACT: begin
                  {ras_n, cas_n, we_n} <= `ENC_ACT;
                  open_r[cmd_addr_r[14:13]] <= 1'b1;
                end
                `OP_RD, `OP_WR: begin
                  // RULE1: command encoding
                  {ras_n, cas_n, we_n} <= (cmd_op_r == `OP_RD) ? `ENC_RD : `ENC_WR;
                  if (cmd_op_r == `OP_WR) wr_ph_r <= 4'h4;
                  if (cmd_addr_r[`AP_BIT]) begin
                    open_r[cmd_addr_r[14:13]] <= 1'b0;
                    bank_hold_r[cmd_addr_r[14:13]] <= ap_hold(cmd_op_r == `OP_WR);
                  end
                end
                `OP_PRE: begin
                  {ras_n, cas_n, we_n} <= `ENC_PRE;
                  // RULE2: ap bit precharges all
                  if (cmd_addr_r[`AP_BIT]) open_r <= 4'h0;
                  else open_r[cmd_addr_r[14:13]] <= 1'b0;
                  tload  <= 1'b1;
                  tcount <= `TRP_CYC;
                end
                `OP_REF: begin
                  {ras_n, cas_n, we_n} <= `ENC_REF;
                  tload  <= 1'b1;
                  tcount <= `TRFC_CYC;
                end
                `OP_BST: {ras_n, cas_n, we_n} <= `ENC_BST;
                default: refused_r <= 1'b1;
              endcase
            end
          end
        end
        S_SREF: begin
          if (sr_exit_r) begin
            // RULE10: exit with cke high, nop
            sr_exit_r <= 1'b0;
            cke       <= 1'b1;
            lock_cnt_r <= `LOCK_WAIT_CYC;
            state_r   <= S_IDLE;
          end else begin
            cke <= 1'b0;
          end
        end
        S_PDN: begin
          if (pd_exit_r) begin
            pd_exit_r <= 1'b0;
            cke       <= 1'b1;
            state_r   <= S_IDLE;
          end else begin
            cke <= 1'b0;
          end
        end
        default: state_r <= S_WAIT;
      endcase
    end
  end
endmodule // ddr_ctl

// >>> bench/ddr_ctl_monitor.sv
// pin checker for the ddr command and init controller
`include "ddr_ctl_consts.vh"
module ddr_ctl_monitor #(
  parameter INIT_WAIT = 50
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        cke,
  input wire        cs_n,
  input wire        ras_n,
  input wire        cas_n,
  input wire        we_n,
  input wire [12:0] addr,
  input wire [1:0]  bank
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // command decode from the pins
  wire [2:0] enc  = {ras_n, cas_n, we_n};
  wire       cmd  = !cs_n && enc != `ENC_NOP;
  wire       mode_register_write  = !cs_n && enc == `ENC_MRS;
  wire       pre  = !cs_n && enc == `ENC_PRE;
  wire       act  = !cs_n && enc == `ENC_ACT;
  wire       rdc  = !cs_n && enc == `ENC_RD;
  wire       acc  = rdc || (!cs_n && enc == `ENC_WR);
  wire       refr = !cs_n && enc == `ENC_REF;
  reg [15:0] age_r;
  reg [3:0]  open_r;
  reg [7:0]  since_pre_r;
  reg [7:0]  lock_r;
  reg [1:0]  nmrs_r;
  reg [1:0]  nref_r;
  reg        pall_r;
  reg [3:0]  hold_r;
  reg [1:0]  hbank_r;
  // shadow state; counters saturate so long runs never wrap
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      age_r <= 16'h0000; open_r <= 4'h0; since_pre_r <= 8'h00; lock_r <= 8'h00;
      nmrs_r <= 2'h0; nref_r <= 2'h0; pall_r <= 1'b0; hold_r <= 4'h0; hbank_r <= 2'h0;
    end else begin
      age_r <= (age_r == 16'hFFFF) ? age_r : age_r + 16'h0001;
      since_pre_r <= pre ? 8'h01 : (since_pre_r == 8'hFF ? 8'hFF : since_pre_r + 8'h01);
      lock_r <= (mode_register_write && bank == 2'h0 && addr[8]) ? 8'd199 : (lock_r != 0 ? lock_r - 8'h01 : 0);
      nmrs_r <= (mode_register_write && nmrs_r != 2'h3) ? nmrs_r + 2'h1 : nmrs_r;
      nref_r <= (refr && nref_r != 2'h3) ? nref_r + 2'h1 : nref_r;
      pall_r <= mode_register_write ? 1'b0 : (pre && addr[`AP_BIT]) ? 1'b1 : pall_r;
      if (act) open_r[bank] <= 1'b1;
      if (pre && addr[`AP_BIT]) open_r <= 4'h0;
      else if (pre || (acc && addr[`AP_BIT])) open_r[bank] <= 1'b0;
      // bank hold windows: bl/2+trp for reads, bl/2+1+twr+trp for writes
      if (acc && addr[`AP_BIT]) begin
        hold_r <= rdc ? 4'd4 : 4'd7;
        hbank_r <= bank;
      end else if (hold_r != 0) begin
        hold_r <= hold_r - 4'h1;
      end
    end
  end
  sequence s_mode_write;
    mode_register_write;
  endsequence
  sequence s_quiet;
    !cmd;
  endsequence
  a_init_quiet: assert property (age_r < INIT_WAIT - 1 |-> !cke && cs_n)
    else $error("command pins active during power-up wait");
  a_cmd_cke_up: assert property (cmd |-> $past(cke))
    else $error("command issued without clock enable high before");
  a_cke_rise: assert property ($rose(cke) |-> !cmd)
    else $error("clock enable rose with a real command");
  a_mrs_spacing: assert property (s_mode_write |=> s_quiet [*2])
    else $error("command inside mode write interval");
  a_mrs_idle: assert property (mode_register_write |-> open_r == 0 && since_pre_r >= `TRP_CYC)
    else $error("mode write with open rows or too soon after precharge");
  a_row_order: assert property ((acc |-> open_r[bank]) and (act |-> !open_r[bank]))
    else $error("access without open row or activate over open row");
  a_read_lock: assert property (rdc |-> lock_r == 0)
    else $error("read before loop lock wait");
  a_ap_hold: assert property ((act || acc || pre) && hold_r != 0 |->
      bank != hbank_r && !(pre && addr[`AP_BIT]))
    else $error("command to bank still auto-precharging");
  a_init_order: assert property (mode_register_write |-> nmrs_r == 3 || (nmrs_r == 0 && bank == 2'b01) ||
      (nmrs_r == 1 && bank == 0 && addr[8]) ||
      (nmrs_r == 2 && bank == 0 && !addr[8] && pall_r && nref_r >= 2))
    else $error("mode writes out of init order");
endmodule // ddr_ctl_monitor
bind ddr_ctl ddr_ctl_monitor #(.INIT_WAIT(INIT_WAIT)) mon (.clk_sys(clk_sys), .rst(rst),
  .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank(bank));

// >>> bench/ddr_sdram_model.sv
// behavioural four-bank ddr memory seen from its pins
`include "ddr_ctl_consts.vh"
module ddr_sdram_model (
  input  wire        clk_sys,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [12:0] addr,
  input  wire [1:0]  bank,
  input  wire [15:0] dq_out,
  input  wire        dq_oe,
  input  wire        lower_byte_mask,
  input  wire        upper_byte_mask,
  output wire [15:0] dq_in,
  output wire        lower_byte_strobe_in,
  output wire        upper_byte_strobe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  reg        cke_q = 0;
  reg [3:0]  open = 0;
  reg [14:0] mode_r = 0;
  reg [14:0] emode_r = 0;
  reg        sref = 0;
  reg        pdown = 0;
  reg [15:0] mem [0:63];
  reg [5:0]  wptr = 0;
  reg [2:0]  rcnt = 0;
  reg [15:0] rword = 0;
  wire [2:0] enc = {ras_n, cas_n, we_n};
  initial for (int i = 0; i < 64; i++) mem[i] = 16'hA5C3 ^ (16'h0101 * i);
  // released lines show the inverse, never a stale value
  assign dq_in = (rcnt != 0) ? rword : ~rword;
  assign lower_byte_strobe_in = rcnt[0];
  assign upper_byte_strobe_in = rcnt[0];
  always @(posedge clk_sys) begin
    cke_q <= cke;
    if (rcnt != 0) rcnt <= rcnt - 3'h1;
    // decode only with clock enable high before
    if (cke_q && !cs_n) case (enc)
      `ENC_ACT: open[bank] <= 1'b1;
      // flag high ignores the bank inputs
      `ENC_PRE: if (addr[`AP_BIT]) open <= 4'h0; else open[bank] <= 1'b0;
      `ENC_MRS: if (bank == 2'b01) emode_r <= {bank, addr}; else mode_r <= {bank, addr};
      `ENC_RD: begin
        rword <= mem[{bank, addr[3:0]}];
        rcnt <= 3'd6;
      end
      `ENC_WR: wptr <= {bank, addr[3:0]};
      `ENC_REF: sref <= !cke;
      default: ;
    endcase
    if (!cke_q && cke) begin
      sref <= 1'b0;
      pdown <= 1'b0;
    end
    if (cke_q && !cke && (cs_n || enc == `ENC_NOP)) pdown <= 1'b1;
    // masks matter only on write beats
    if (dq_oe && !lower_byte_mask) mem[wptr][7:0] <= dq_out[7:0];
    if (dq_oe && !upper_byte_mask) mem[wptr][15:8] <= dq_out[15:8];
  end
endmodule // ddr_sdram_model

// >>> bench/ddr_ctl_tb_top.sv
// testbench for the ddr command and init controller
`include "ddr_ctl_consts.vh"
module ddr_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, rv;
  wire  [31:0] reg_rdata;
  wire         cke, cs_n, ras_n, cas_n, we_n, dq_oe, strobe_oe, lower_byte_mask, upper_byte_mask;
  wire         lower_byte_strobe_out, upper_byte_strobe_out;
  wire         lower_byte_strobe_in, upper_byte_strobe_in;
  wire  [12:0] addr;
  wire  [1:0]  bank;
  wire  [15:0] dq_out, dq_in;
  integer      n_mismatch = 0, checked = 0, seed = 75258;
  logic [5:0]  seen [$];
  logic [15:0] shadow [0:63];
  logic [15:0] d;
  logic [1:0]  bk, m;
  logic [3:0]  col;
  ddr_ctl #(.INIT_WAIT(50)) uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank, .dq_out, .dq_oe, .dq_in,
    .lower_byte_strobe_out, .upper_byte_strobe_out, .strobe_oe, .lower_byte_strobe_in,
    .upper_byte_strobe_in, .lower_byte_mask, .upper_byte_mask);
  ddr_sdram_model mem (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank, .dq_out,
    .dq_oe, .lower_byte_mask, .upper_byte_mask, .dq_in, .lower_byte_strobe_in,
    .upper_byte_strobe_in);
  initial forever #5 clk_sys = ~clk_sys;
  // log init commands; mode writes keep bank and loop-reset bit, precharge its flag
  always @(posedge clk_sys)
    if (!rst && !cs_n && {ras_n, cas_n, we_n} != `ENC_NOP && seen.size() < 7)
      seen.push_back({{ras_n, cas_n, we_n} == `ENC_MRS ? {bank, addr[8]} :
                      {2'b00, addr[`AP_BIT] & ~we_n}, ras_n, cas_n, we_n});
  function automatic logic [5:0] init_step(int i);
    logic [5:0] t [7] = '{6'o12, 6'o20, 6'o10, 6'o12, 6'o01, 6'o01, 6'o00};
    return t[i];
  endfunction
  function automatic logic [15:0] merge(logic [15:0] o, n, logic [1:0] k);
    return {k[1] ? o[15:8] : n[15:8], k[0] ? o[7:0] : n[7:0]};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 rv = reg_rdata;
  endtask
  // bounded wait for a register bit to reach a value
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    rd(a);
    for (int i = 0; i < 400 && rv[b] !== v; i++) rd(a);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] k, input logic [12:0] a);
    wr(`REG_ADDR, {17'h0, k, a});
    wr(`REG_CMD, {29'h0, op});
    poll(`REG_STATUS, `ST_BUSY, 0);
    poll(`REG_CMD, 3, 0);
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog sized well above the longest expected run
  initial begin
    repeat (80000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    for (int i = 0; i < 64; i++) shadow[i] = 16'hA5C3 ^ (16'h0101 * i);
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    chk(cke, 0);
    rd(`REG_MODE);
    chk(rv, {17'h0, `MODE_RST});
    rd(`REG_EMODE);
    chk(rv, {17'h0, `EMODE_RST});
    // unmapped indices ignore writes and read zero
    for (int a = 8; a < 16; a++) begin
      wr(a[3:0], $random(seed));
      rd(a[3:0]);
      chk(rv, 0);
    end
    $display("register test done");
    poll(`REG_STATUS, `ST_INIT_DONE, 1);
    chk(rv[`ST_INIT_DONE], 1);
    for (int i = 0; i < 7; i++) chk(seen[i], init_step(i));
    chk(mem.mode_r, `MODE_RST);
    chk(mem.emode_r[12:0], `EMODE_RST & 15'h1FFF);
    $display("init test done");
    // read to a closed row, then one after activating that row
    cmd(`OP_RD, 2'h1, 13'h0000);
    chk(rv[3:0], {1'b0, `OP_RD});
    rd(`REG_STATUS);
    chk(rv[`ST_REFUSED], 1);
    wr(`REG_CTRL, 32'h1);
    cmd(`OP_ACT, 2'h1, 13'h0005);
    cmd(`OP_RD, 2'h1, 13'h0000);
    rd(`REG_STATUS);
    chk(rv[`ST_REFUSED], 0);
    wr(`REG_CTRL, 32'h1);
    cmd(`OP_PRE, 2'h1, 13'h0000);
    repeat (200) @(posedge clk_sys);
    $display("refusal test done");
    // masked writes then reads, alternating auto-precharge
    for (int i = 0; i < 8; i++) begin
      bk = $random(seed);
      col = $random(seed);
      d = $random(seed);
      m = (i == 0) ? 2'b11 : (i == 1) ? 2'b00 : $random(seed);
      cmd(`OP_ACT, bk, $random(seed));
      wr(`REG_WDATA, {14'h0, m, d});
      cmd(`OP_WR, bk, {9'h0, col});
      shadow[{bk, col}] = merge(shadow[{bk, col}], d, m);
      cmd(`OP_RD, bk, {2'b00, i[0], 6'h0, col});
      repeat (3) @(posedge clk_sys);
      rd(`REG_RDATA);
      chk(rv[15:0], shadow[{bk, col}]);
      if (!i[0]) cmd(`OP_PRE, ~bk, 13'h0400);
      repeat (12) @(posedge clk_sys);
    end
    rd(`REG_STATUS);
    chk(rv[`ST_ROW_OPEN], 0);
    $display("data test done");
    wr(`REG_CTRL, 32'h1 << `CTRL_SR_ENTER);
    poll(`REG_STATUS, `ST_SELF_REF, 1);
    chk({rv[`ST_SELF_REF], cke, mem.sref}, 3'b101);
    wr(`REG_CTRL, 32'h1 << `CTRL_SR_EXIT);
    poll(`REG_STATUS, `ST_SELF_REF, 0);
    chk({rv[`ST_SELF_REF], cke, mem.sref}, 3'b010);
    $display("self refresh test done");
    cmd(`OP_ACT, 2'h2, 13'h0011);
    wr(`REG_CTRL, 32'h1 << `CTRL_PD_ENTER);
    poll(`REG_STATUS, `ST_POWER_DOWN, 1);
    chk({rv[`ST_POWER_DOWN], cke, mem.pdown}, 3'b101);
    wr(`REG_CTRL, 32'h1 << `CTRL_PD_EXIT);
    poll(`REG_STATUS, `ST_POWER_DOWN, 0);
    chk({rv[`ST_POWER_DOWN], cke, mem.pdown}, 3'b010);
    cmd(`OP_RD, 2'h2, 13'h0000);
    rd(`REG_STATUS);
    chk(rv[`ST_REFUSED], 1);
    $display("power-down test done");
    tally_and_finish;
  end
endmodule // ddr_ctl_tb_top
